// >>> hw/pld_consts.svh
// Offsets, field positions, reset values and timing figures of the link drop register slice
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PLD_OFF_CTRL 8'h2d
`define PLD_OFF_THR 8'h2e
`define PLD_OFF_MISC 8'h31
`define PLD_OFF_MAC 8'h32

// ****************************************************************
// Fast drop control fields
// ****************************************************************
`define PLD_CTRL_FORCE 15
`define PLD_CTRL_EN 14
`define PLD_CTRL_CAUSE_HI 12
`define PLD_CTRL_CAUSE_LO 8
`define PLD_CTRL_SRC_HI 4
`define PLD_CTRL_SRC_LO 0
`define PLD_CAUSE_ENERGY 0
`define PLD_CAUSE_DESCR 4

// ****************************************************************
// Threshold fields
// ****************************************************************
`define PLD_THR_AUX1_HI 10
`define PLD_THR_AUX1_LO 8
`define PLD_THR_AUX0_HI 6
`define PLD_THR_AUX0_LO 4
`define PLD_THR_ENERGY_HI 2
`define PLD_THR_ENERGY_LO 0
`define PLD_THR_AUX_RST 3'h2
`define PLD_THR_ENERGY_RST 3'h1
`define PLD_THR_ENERGY_STRAP 3'h2

// ****************************************************************
// Miscellaneous configuration fields
// ****************************************************************
`define PLD_MISC_ONE_BIT 12
`define PLD_MISC_SPARE 8
`define PLD_MISC_TEST 7
`define PLD_MISC_TMR_HI 6
`define PLD_MISC_TMR_LO 5
`define PLD_MISC_FIX_HI 4
`define PLD_MISC_FIX_LO 1
`define PLD_MISC_MIRROR 0
`define PLD_MISC_FIX_VAL 4'h8
`define PLD_MISC_TMR_RST 2'h1
`define PLD_TMR_SEL_16MS 2'h0
`define PLD_TMR_SEL_2US 2'h1
`define PLD_TMR_SEL_800US 2'h2

// ****************************************************************
// MAC interface control fields
// ****************************************************************
`define PLD_MAC_EN 7
`define PLD_MAC_RXTH_HI 6
`define PLD_MAC_RXTH_LO 5
`define PLD_MAC_TXTH_HI 4
`define PLD_MAC_TXTH_LO 3
`define PLD_MAC_TXSKEW 1
`define PLD_MAC_RXSKEW 0
`define PLD_MAC_TH_RST 2'h2

// ****************************************************************
// Timing, in microseconds, at the core clock rate
// ****************************************************************
`define PLD_CLK_MHZ 50
`define PLD_T_16MS_US 16000
`define PLD_T_11MS_US 11000
`define PLD_T_800US_US 800
`define PLD_T_2US_US 2

`endif

// >>> hw/pld_pkg.sv
// Types shared by the link drop register slice
package pld_pkg;
   typedef logic [15:0] pld_word_type;
   typedef logic [7:0] pld_addr_type;
   typedef enum logic [0:0] {
      PLD_ST_STRAP = 1'b0,
      PLD_ST_RUN = 1'b1
   } pld_state_type;
endpackage : pld_pkg

// >>> hw/pld_regs.sv
// Fast link drop, miscellaneous configuration and MAC interface control registers
// Summary of operation
// - Force-drop bit makes partner drop link whenever no signal is received.
// - Fast-drop enable applies fast link drop to 1000BASE-T links only.
// - Each cause flag latches high when enabled, active and dropping link.
// - Cause bits: 12 descrambler, 11 rx errors, 10 MLT3, 9 SNR, 8 energy.
// - Source bits 4 to 0 enable each drop criterion independently.
// - Energy loss asserts when accumulator is below threshold; reset value 0x1.
// - With fast drop strapped on, threshold comes out of reset as 0x2.
// - Receive-control strap mode1 or mode2 enters test mode; writing zero overrules.
// - Timer field picks 16ms, 2us, 800us or 11ms; reset value 01.
// - Misc bits 4 to 1 ignore writes and read 1000.
// - Misc bit 0 enables lane mirroring; strap gives reset value; writable.
// - Interface-enable bit turns the MAC interface on; reset one or strap.
// - Receive FIFO half-full threshold field, reset value 10.
// - Transmit FIFO half-full threshold field, reset value 10.
// - Transmit skew bit shifts transmit clock against data; reset one.
// - Receive skew bit shifts receive clock against data; reset one.
// - MAC control bits 15 to 8 and 2 ignore writes, read zero.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "pld_consts.svh"

module pld_regs #(
   parameter int unsigned CYC_16MS = `PLD_T_16MS_US * `PLD_CLK_MHZ,
   parameter int unsigned CYC_11MS = `PLD_T_11MS_US * `PLD_CLK_MHZ,
   parameter int unsigned CYC_800US = `PLD_T_800US_US * `PLD_CLK_MHZ,
   parameter bit MAC_EN_BY_STRAP = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire pld_pkg::pld_addr_type reg_addr,
   input wire pld_pkg::pld_word_type reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output pld_pkg::pld_word_type reg_rdata,
   input wire logic [4:1] crit_active,
   input wire logic [2:0] energy_accum,
   input wire logic link_1000,
   input wire logic no_signal,
   input wire logic strap_fast_drop,
   input wire logic strap_test_mode,
   input wire logic strap_mirror,
   input wire logic strap_mac_en,
   output logic partner_drop_req,
   output logic fast_drop_req,
   output logic energy_lost,
   output logic internal_test_mode,
   output logic [19:0] neg_timer_cycles,
   output logic lane_mirror_en,
   output logic mac_if_en,
   output logic [1:0] rx_fifo_half_threshold,
   output logic [1:0] tx_fifo_half_threshold,
   output logic tx_clk_shift,
   output logic rx_clk_shift
);
   import pld_pkg::*;

   localparam logic [19:0] CYC_2US = 20'(`PLD_T_2US_US * `PLD_CLK_MHZ);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic hit(input pld_addr_type addr, input pld_addr_type off);
      hit = (addr == off);
   endfunction : hit

   logic wr_ctrl;
   logic wr_thr;
   logic wr_misc;
   logic wr_mac;
   logic rd_ctrl;
   assign wr_ctrl = reg_wr && hit(reg_addr, `PLD_OFF_CTRL);
   assign wr_thr = reg_wr && hit(reg_addr, `PLD_OFF_THR);
   assign wr_misc = reg_wr && hit(reg_addr, `PLD_OFF_MISC);
   assign wr_mac = reg_wr && hit(reg_addr, `PLD_OFF_MAC);
   assign rd_ctrl = reg_rd && hit(reg_addr, `PLD_OFF_CTRL);

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   // Straps are sampled on the first edge after reset release, never under reset
   pld_state_type state;
   logic strap_load;
   assign strap_load = (state == PLD_ST_STRAP);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PLD_ST_STRAP;
      end else begin
         case (state)
            PLD_ST_STRAP: state <= PLD_ST_RUN;
            PLD_ST_RUN: state <= PLD_ST_RUN;
            default: state <= PLD_ST_STRAP;
         endcase
      end
   end

   // ****************************************************************
   // Fast drop control
   // ****************************************************************
   logic force_drop;
   logic fast_drop_enable;
   logic [4:0] fast_drop_cause_enables;
   logic [4:0] fast_drop_cause_latched;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         force_drop <= 1'b0;
      end else if (wr_ctrl) begin
         force_drop <= reg_wdata[`PLD_CTRL_FORCE];
      end
   end

   // Software is trusted to leave this clear during link bring-up
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_drop_enable <= 1'b0;
      end else if (strap_load) begin
         fast_drop_enable <= strap_fast_drop;
      end else if (wr_ctrl) begin
         fast_drop_enable <= reg_wdata[`PLD_CTRL_EN];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_drop_cause_enables <= 5'h0;
      end else if (wr_ctrl) begin
         fast_drop_cause_enables <= reg_wdata[`PLD_CTRL_SRC_HI:`PLD_CTRL_SRC_LO];
      end
   end

   // ****************************************************************
   // Energy threshold and drop criteria
   // ****************************************************************
   logic [2:0] energy_loss_threshold;
   logic [2:0] thr_aux0;
   logic [2:0] thr_aux1;
   logic energy_now;
   logic [4:0] crit_now;
   logic [4:0] trig;
   logic fast_gate;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         energy_loss_threshold <= `PLD_THR_ENERGY_RST;
      end else if (strap_load && strap_fast_drop) begin
         energy_loss_threshold <= `PLD_THR_ENERGY_STRAP;
      end else if (wr_thr) begin
         energy_loss_threshold <= reg_wdata[`PLD_THR_ENERGY_HI:`PLD_THR_ENERGY_LO];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         thr_aux0 <= `PLD_THR_AUX_RST;
         thr_aux1 <= `PLD_THR_AUX_RST;
      end else if (wr_thr) begin
         thr_aux0 <= reg_wdata[`PLD_THR_AUX0_HI:`PLD_THR_AUX0_LO];
         thr_aux1 <= reg_wdata[`PLD_THR_AUX1_HI:`PLD_THR_AUX1_LO];
      end
   end

   assign energy_now = (energy_accum < energy_loss_threshold);
   assign crit_now = {crit_active, energy_now};
   // Fast drop only acts on gigabit links
   assign fast_gate = fast_drop_enable && link_1000;
   assign trig = crit_now & fast_drop_cause_enables & {5{fast_gate}};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         energy_lost <= 1'b0;
         fast_drop_req <= 1'b0;
      end else begin
         energy_lost <= energy_now;
         fast_drop_req <= |trig;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         partner_drop_req <= 1'b0;
      end else begin
         partner_drop_req <= force_drop && no_signal;
      end
   end

   // ****************************************************************
   // Latched causes
   // ****************************************************************
   // A cause arriving in the read cycle survives the clear
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_cause
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               fast_drop_cause_latched[gi] <= 1'b0;
            end else if (trig[gi]) begin
               fast_drop_cause_latched[gi] <= 1'b1;
            end else if (rd_ctrl) begin
               fast_drop_cause_latched[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Miscellaneous configuration
   // ****************************************************************
   logic misc_spare;
   logic [1:0] serial_negotiation_timer;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         internal_test_mode <= 1'b0;
      end else if (strap_load) begin
         internal_test_mode <= strap_test_mode;
      end else if (wr_misc) begin
         internal_test_mode <= reg_wdata[`PLD_MISC_TEST];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lane_mirror_en <= 1'b0;
      end else if (strap_load) begin
         lane_mirror_en <= strap_mirror;
      end else if (wr_misc) begin
         lane_mirror_en <= reg_wdata[`PLD_MISC_MIRROR];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         misc_spare <= 1'b0;
         serial_negotiation_timer <= `PLD_MISC_TMR_RST;
      end else if (wr_misc) begin
         misc_spare <= reg_wdata[`PLD_MISC_SPARE];
         serial_negotiation_timer <= reg_wdata[`PLD_MISC_TMR_HI:`PLD_MISC_TMR_LO];
      end
   end

   // Duration in core clock cycles for the serial negotiation timer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         neg_timer_cycles <= CYC_2US;
      end else begin
         if (serial_negotiation_timer == `PLD_TMR_SEL_16MS) begin
            neg_timer_cycles <= 20'(CYC_16MS);
         end else if (serial_negotiation_timer == `PLD_TMR_SEL_2US) begin
            neg_timer_cycles <= CYC_2US;
         end else if (serial_negotiation_timer == `PLD_TMR_SEL_800US) begin
            neg_timer_cycles <= 20'(CYC_800US);
         end else begin
            neg_timer_cycles <= 20'(CYC_11MS);
         end
      end
   end

   // ****************************************************************
   // MAC interface control
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mac_if_en <= 1'b1;
      end else if (strap_load && MAC_EN_BY_STRAP) begin
         mac_if_en <= strap_mac_en;
      end else if (wr_mac) begin
         mac_if_en <= reg_wdata[`PLD_MAC_EN];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_fifo_half_threshold <= `PLD_MAC_TH_RST;
         tx_fifo_half_threshold <= `PLD_MAC_TH_RST;
         tx_clk_shift <= 1'b1;
         rx_clk_shift <= 1'b1;
      end else if (wr_mac) begin
         rx_fifo_half_threshold <= reg_wdata[`PLD_MAC_RXTH_HI:`PLD_MAC_RXTH_LO];
         tx_fifo_half_threshold <= reg_wdata[`PLD_MAC_TXTH_HI:`PLD_MAC_TXTH_LO];
         tx_clk_shift <= reg_wdata[`PLD_MAC_TXSKEW];
         rx_clk_shift <= reg_wdata[`PLD_MAC_RXSKEW];
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   pld_word_type next_rdata;

   always_comb begin
      next_rdata = 16'h0000;
      if (hit(reg_addr, `PLD_OFF_CTRL)) begin
         next_rdata[`PLD_CTRL_FORCE] = force_drop;
         next_rdata[`PLD_CTRL_EN] = fast_drop_enable;
         next_rdata[`PLD_CTRL_CAUSE_HI:`PLD_CTRL_CAUSE_LO] = fast_drop_cause_latched;
         next_rdata[`PLD_CTRL_SRC_HI:`PLD_CTRL_SRC_LO] = fast_drop_cause_enables;
      end else if (hit(reg_addr, `PLD_OFF_THR)) begin
         next_rdata[`PLD_THR_AUX1_HI:`PLD_THR_AUX1_LO] = thr_aux1;
         next_rdata[`PLD_THR_AUX0_HI:`PLD_THR_AUX0_LO] = thr_aux0;
         next_rdata[`PLD_THR_ENERGY_HI:`PLD_THR_ENERGY_LO] = energy_loss_threshold;
      end else if (hit(reg_addr, `PLD_OFF_MISC)) begin
         next_rdata[`PLD_MISC_ONE_BIT] = 1'b1;
         next_rdata[`PLD_MISC_SPARE] = misc_spare;
         next_rdata[`PLD_MISC_TEST] = internal_test_mode;
         next_rdata[`PLD_MISC_TMR_HI:`PLD_MISC_TMR_LO] = serial_negotiation_timer;
         next_rdata[`PLD_MISC_FIX_HI:`PLD_MISC_FIX_LO] = `PLD_MISC_FIX_VAL;
         next_rdata[`PLD_MISC_MIRROR] = lane_mirror_en;
      end else if (hit(reg_addr, `PLD_OFF_MAC)) begin
         // Upper byte and bit 2 stay zero
         next_rdata[`PLD_MAC_EN] = mac_if_en;
         next_rdata[`PLD_MAC_RXTH_HI:`PLD_MAC_RXTH_LO] = rx_fifo_half_threshold;
         next_rdata[`PLD_MAC_TXTH_HI:`PLD_MAC_TXTH_LO] = tx_fifo_half_threshold;
         next_rdata[`PLD_MAC_TXSKEW] = tx_clk_shift;
         next_rdata[`PLD_MAC_RXSKEW] = rx_clk_shift;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_timer_write(logic [1:0] sel);
      wr_misc && reg_wdata[`PLD_MISC_TMR_HI:`PLD_MISC_TMR_LO] == sel && !strap_load;
   endsequence

   sequence s_ctrl_read;
      rd_ctrl && trig == 5'h0;
   endsequence

   property p_force_drop;
      force_drop && no_signal |=> partner_drop_req;
   endproperty
   a_force_drop: assert property (p_force_drop) else $error("partner drop missed");

   property p_no_fast_off_gig;
      !link_1000 |=> !fast_drop_req;
   endproperty
   a_no_fast_off_gig: assert property (p_no_fast_off_gig) else $error("fast drop off gigabit");

   property p_cause_sticky;
      !rd_ctrl |=> (fast_drop_cause_latched & $past(fast_drop_cause_latched))
         == $past(fast_drop_cause_latched);
   endproperty
   a_cause_sticky: assert property (p_cause_sticky) else $error("cause flag lost");

   property p_energy_cause;
      fast_gate && fast_drop_cause_enables[`PLD_CAUSE_ENERGY] && energy_now
         |=> fast_drop_cause_latched[`PLD_CAUSE_ENERGY] && fast_drop_req;
   endproperty
   a_energy_cause: assert property (p_energy_cause) else $error("energy cause not latched");

   property p_src_gate;
      fast_drop_cause_enables == 5'h0 |=> !fast_drop_req;
   endproperty
   a_src_gate: assert property (p_src_gate) else $error("drop without enabled source");

   property p_energy_cmp;
      energy_accum < energy_loss_threshold |=> energy_lost;
   endproperty
   a_energy_cmp: assert property (p_energy_cmp) else $error("energy loss not flagged");

   property p_strap_thr;
      strap_load && strap_fast_drop |=> energy_loss_threshold == `PLD_THR_ENERGY_STRAP;
   endproperty
   a_strap_thr: assert property (p_strap_thr) else $error("strap threshold wrong");

   property p_test_clear;
      wr_misc && !reg_wdata[`PLD_MISC_TEST] && !strap_load |=> !internal_test_mode;
   endproperty
   a_test_clear: assert property (p_test_clear) else $error("test mode not overruled");

   property p_timer_16ms;
      s_timer_write(`PLD_TMR_SEL_16MS) ##1 !wr_misc |=> neg_timer_cycles == 20'(CYC_16MS);
   endproperty
   a_timer_16ms: assert property (p_timer_16ms) else $error("timer 16ms wrong");

   property p_misc_fixed;
      reg_rd && hit(reg_addr, `PLD_OFF_MISC)
         |=> reg_rdata[`PLD_MISC_FIX_HI:`PLD_MISC_FIX_LO] == `PLD_MISC_FIX_VAL;
   endproperty
   a_misc_fixed: assert property (p_misc_fixed) else $error("misc fixed bits wrong");

   property p_mac_reserved;
      reg_rd && hit(reg_addr, `PLD_OFF_MAC) |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[2];
   endproperty
   a_mac_reserved: assert property (p_mac_reserved) else $error("reserved bits nonzero");

   property p_read_clears;
      s_ctrl_read |=> fast_drop_cause_latched == 5'h0;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("cause not cleared on read");

endmodule : pld_regs
`default_nettype wire

// >>> test/pld_tb.sv
// Self-checking bench for the link drop and MAC interface register slice
`timescale 1ns/100ps
`default_nettype none
`include "pld_consts.svh"

module testbench;
   import pld_pkg::*;
   localparam pld_addr_type a_ctrl = `PLD_OFF_CTRL;
   localparam pld_addr_type a_thr = `PLD_OFF_THR;
   localparam pld_addr_type a_misc = `PLD_OFF_MISC;
   localparam pld_addr_type a_mac = `PLD_OFF_MAC;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   pld_addr_type reg_addr = 8'h00;
   pld_word_type reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   pld_word_type reg_rdata;
   logic [4:1] crit_active = 4'h0;
   logic [2:0] energy_accum = 3'h7;
   logic link_1000 = 1'b0;
   logic no_signal = 1'b0;
   logic strap_fast_drop = 1'b0;
   logic strap_test_mode = 1'b0;
   logic strap_mirror = 1'b0;
   logic strap_mac_en = 1'b0;
   logic partner_drop_req, fast_drop_req, energy_lost, internal_test_mode, lane_mirror_en;
   logic mac_if_en, tx_clk_shift, rx_clk_shift;
   logic [19:0] neg_timer_cycles;
   logic [1:0] rx_fifo_half_threshold, tx_fifo_half_threshold;
   logic [19:0] tmr_exp [4] = '{20'h0_012c, 20'h0_0064, 20'h0_0032, 20'h0_00c8};
   int n_mismatch = 0;
   int cmp_count = 0;

   always #10 core_clk = ~core_clk;

   // Short timer counts keep the expected timer values small
   pld_regs #(.CYC_16MS(300), .CYC_11MS(200), .CYC_800US(50), .MAC_EN_BY_STRAP(1'b0)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crit_active(crit_active),
      .energy_accum(energy_accum), .link_1000(link_1000), .no_signal(no_signal),
      .strap_fast_drop(strap_fast_drop), .strap_test_mode(strap_test_mode),
      .strap_mirror(strap_mirror), .strap_mac_en(strap_mac_en),
      .partner_drop_req(partner_drop_req), .fast_drop_req(fast_drop_req),
      .energy_lost(energy_lost), .internal_test_mode(internal_test_mode),
      .neg_timer_cycles(neg_timer_cycles), .lane_mirror_en(lane_mirror_en),
      .mac_if_en(mac_if_en), .rx_fifo_half_threshold(rx_fifo_half_threshold),
      .tx_fifo_half_threshold(tx_fifo_half_threshold), .tx_clk_shift(tx_clk_shift),
      .rx_clk_shift(rx_clk_shift));

   // ****************************************************************
   // Bus and check tasks
   // ****************************************************************
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic wr(input pld_addr_type a, input pld_word_type d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input pld_addr_type a, input pld_word_type exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(20'(reg_rdata), 20'(exp));
   endtask : rd_chk

   task automatic do_reset(input logic fd, input logic tm, input logic mir, input logic me);
      @(posedge core_clk);
      rst_n <= 1'b0;
      strap_fast_drop <= fd;
      strap_test_mode <= tm;
      strap_mirror <= mir;
      strap_mac_en <= me;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask : do_reset

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      do_reset(1'b0, 1'b0, 1'b0, 1'b1);
      rd_chk(a_ctrl, 16'h0000);
      rd_chk(a_thr, 16'h0221);
      rd_chk(a_misc, 16'h1030);
      rd_chk(a_mac, 16'h00d3);
      chk(20'({mac_if_en, rx_fifo_half_threshold, tx_fifo_half_threshold, tx_clk_shift,
         rx_clk_shift}), 20'h0_006b);
      chk(neg_timer_cycles, 20'h0_0064);
      wr(a_mac, 16'hffff);
      rd_chk(a_mac, 16'h00fb);
      chk(20'({mac_if_en, rx_fifo_half_threshold, tx_fifo_half_threshold, tx_clk_shift,
         rx_clk_shift}), 20'h0_007f);
      wr(a_mac, 16'h0000);
      rd_chk(a_mac, 16'h0000);
      chk(20'({mac_if_en, tx_clk_shift, rx_clk_shift}), 20'h0_0000);
      wr(a_misc, 16'hffff);
      rd_chk(a_misc, 16'h11f1);
      chk(20'({internal_test_mode, lane_mirror_en}), 20'h0_0003);
      wr(a_misc, 16'h0000);
      rd_chk(a_misc, 16'h1010);
      chk(20'(lane_mirror_en), 20'h0_0000);
      for (int i = 0; i < 4; i++) begin
         wr(a_misc, 16'(i << 5));
         tick(2);
         chk(neg_timer_cycles, tmr_exp[i]);
      end
      // Unmapped offset: write dropped, read answers zero
      wr(8'h30, 16'hffff);
      rd_chk(8'h30, 16'h0000);
      rd_chk(a_mac, 16'h0000);
      // Fast drop is switched on only once the link is up
      @(posedge core_clk);
      link_1000 <= 1'b1;
      wr(a_ctrl, 16'h401f);
      @(posedge core_clk);
      crit_active <= 4'b1000;
      tick(2);
      chk(20'(fast_drop_req), 20'h0_0001);
      rd_chk(a_ctrl, 16'h501f);
      rd_chk(a_ctrl, 16'h501f);
      @(posedge core_clk);
      crit_active <= 4'b0000;
      tick(2);
      chk(20'(fast_drop_req), 20'h0_0000);
      rd_chk(a_ctrl, 16'h501f);
      rd_chk(a_ctrl, 16'h401f);
      // One-cycle pulse of each criterion must still latch its own flag
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk);
         if (i == 0) energy_accum <= 3'h0;
         else crit_active <= 4'(1 << (i - 1));
         @(posedge core_clk);
         energy_accum <= 3'h7;
         crit_active <= 4'h0;
         tick(3);
         rd_chk(a_ctrl, 16'h401f | 16'(1 << (8 + i)));
      end
      wr(a_ctrl, 16'h4017);
      @(posedge core_clk);
      crit_active <= 4'b0100;
      tick(3);
      chk(20'(fast_drop_req), 20'h0_0000);
      rd_chk(a_ctrl, 16'h4017);
      wr(a_ctrl, 16'h0017);
      tick(3);
      chk(20'(fast_drop_req), 20'h0_0000);
      @(posedge core_clk);
      link_1000 <= 1'b0;
      wr(a_ctrl, 16'h401f);
      tick(3);
      chk(20'(fast_drop_req), 20'h0_0000);
      rd_chk(a_ctrl, 16'h401f);
      @(posedge core_clk);
      crit_active <= 4'h0;
      no_signal <= 1'b1;
      tick(3);
      chk(20'(partner_drop_req), 20'h0_0000);
      wr(a_ctrl, 16'h8000);
      tick(2);
      chk(20'(partner_drop_req), 20'h0_0001);
      @(posedge core_clk);
      no_signal <= 1'b0;
      tick(2);
      chk(20'(partner_drop_req), 20'h0_0000);
      do_reset(1'b1, 1'b1, 1'b1, 1'b0);
      rd_chk(a_thr, 16'h0222);
      rd_chk(a_ctrl, 16'h4000);
      rd_chk(a_misc, 16'h10b1);
      rd_chk(a_mac, 16'h00d3);
      @(posedge core_clk);
      energy_accum <= 3'h1;
      tick(2);
      chk(20'(energy_lost), 20'h0_0001);
      wr(a_thr, 16'h0221);
      tick(2);
      chk(20'(energy_lost), 20'h0_0000);
      wr(a_misc, 16'h1030);
      tick(1);
      chk(20'({internal_test_mode, lane_mirror_en}), 20'h0_0000);
      summarize();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      summarize();
   end
endmodule : testbench
`default_nettype wire
